// ==== design/cpc_pkg.sv ====
package cpc_pkg;
    // clock and time base
    localparam int unsigned CLK_FREQ_HZ      = 100_000_000;
    localparam int unsigned BLINK_FREQ_HZ    = 1;
    localparam int unsigned BLINK_HALF_CYC   = CLK_FREQ_HZ / (2 * BLINK_FREQ_HZ);
    localparam int unsigned EVENT_PULSE_US   = 256;
    localparam int unsigned EVENT_PULSE_CYC  = EVENT_PULSE_US * (CLK_FREQ_HZ / 1_000_000);
    localparam int unsigned SHIP_HOLD_MS     = 2;
    localparam int unsigned SHIP_HOLD_CYC    = (SHIP_HOLD_MS * (CLK_FREQ_HZ / 1000) + 0);

    // charge configuration field positions and charge mode code
    localparam int unsigned CFG_BOOST_BIT    = 5;
    localparam int unsigned CFG_MODE_HI      = 5;
    localparam int unsigned CFG_MODE_LO      = 4;
    localparam logic [1:0]  CFG_MODE_CHARGE  = 2'h1;

    // input source field positions and limit codes
    localparam int unsigned SRC_LIM_HI       = 2;
    localparam int unsigned SRC_LIM_LO       = 0;
    localparam logic [2:0]  LIM_100MA        = 3'h0;
    localparam logic [2:0]  LIM_500MA        = 3'h2;

    // reset values
    localparam logic        BATSW_RST        = 1'b1;
    localparam logic [2:0]  LIM_RST          = 3'h0;

    typedef enum logic {
        CPC_EV_IDLE,
        CPC_EV_PULSE
    } cpc_ev_state_t;
endpackage : cpc_pkg

// ==== design/cpc_half_divider.sv ====
`timescale 1ns/10ps
// square wave of 2*HALF_CYC cycles, phase restarts whenever en drops
module cpc_half_divider
    import cpc_pkg::*;
#(
    parameter int unsigned HALF_CYC = BLINK_HALF_CYC
) (
    input  wire logic mclk,     // system clock
    input  wire logic rst,      // async reset
    input  wire logic en,       // run the divider
    output logic      phase_q   // high in first half period after a cycle with en low
);
    localparam int unsigned CW = (HALF_CYC > 1) ? $clog2(HALF_CYC) : 1;
    localparam logic [CW-1:0] LAST = CW'(HALF_CYC - 1);

    logic [CW-1:0] cnt_q;

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            cnt_q <= '0;
        end else if (!en || cnt_q == LAST) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_q + 1'b1;
        end
    end

    // holding the high phase while en is low makes a new fault visible at once; reset loads the low phase
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            phase_q <= 1'b0;
        end else if (!en) begin
            phase_q <= 1'b1;
        end else if (cnt_q == LAST) begin
            phase_q <= !phase_q;
        end
    end
endmodule : cpc_half_divider

// ==== design/cpc_ship_exit.sv ====
`timescale 1ns/10ps
module cpc_ship_exit
    import cpc_pkg::*;
#(
    parameter int unsigned HOLD_CYC = SHIP_HOLD_CYC
) (
    input  wire logic mclk,     // system clock
    input  wire logic rst,      // async reset
    input  wire logic pin,      // ship exit pin level
    output logic      exit_q    // one-cycle exit pulse
);
    localparam int unsigned CW = $clog2(HOLD_CYC + 1);
    localparam logic [CW-1:0] LAST = CW'(HOLD_CYC - 1);

    logic          prev_q;
    logic          armed_q;
    logic [CW-1:0] cnt_q;

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            prev_q <= 1'b1;
        end else begin
            prev_q <= pin;
        end
    end

    // a level held high since reset is no edge and never exits
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            armed_q <= 1'b0;
            cnt_q   <= '0;
        end else if (!pin) begin
            armed_q <= 1'b0;
            cnt_q   <= '0;
        end else if (!prev_q) begin
            armed_q <= 1'b1;
            cnt_q   <= '0;
        end else if (armed_q) begin
            armed_q <= (cnt_q != LAST);
            cnt_q   <= cnt_q + 1'b1;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            exit_q <= 1'b0;
        end else begin
            exit_q <= armed_q && pin && (cnt_q == LAST);
        end
    end
endmodule : cpc_ship_exit

// ==== design/cpc_pin_control.sv ====
`timescale 1ns/10ps
module cpc_pin_control
    import cpc_pkg::*;
#(
    parameter int unsigned BLINK_HALF  = BLINK_HALF_CYC,
    parameter int unsigned EVENT_CYC   = EVENT_PULSE_CYC,
    parameter int unsigned SHIP_CYC    = SHIP_HOLD_CYC
) (
    input  wire logic       mclk,                     // 100 MHz clock
    input  wire logic       rst,                      // async reset, high
    input  wire logic [7:0] charge_config_reg,        // charge configuration bits
    input  wire logic [7:0] input_source_reg,         // input source bits
    input  wire logic       host_limit_boost_pin,     // limit select / boost enable
    input  wire logic       charge_enable_n_pin,      // charge enable, low active
    input  wire logic       source_is_host,           // source select pin level
    input  wire logic [2:0] input_limit_resistor_pin, // resistor limit as code
    input  wire logic       thermistor_sense,         // high when in window
    input  wire logic       charging,                 // core is charging
    input  wire logic       fault_any,                // any fault present
    input  wire logic       status_change,            // status change pulse
    input  wire logic       above_undervoltage_lockout, // input above lockout
    input  wire logic       input_overvoltage,        // input above overvoltage
    input  wire logic       above_sleep,              // input above sleep level
    input  wire logic       input_limit_zero,         // limit at or below 30 mA
    input  wire logic       ship_exit_pin,            // ship exit pin level
    input  wire logic       ship_enter,               // request ship mode
    output logic            stat_o,                   // status pin drive level
    output logic            stat_oe,                  // status pin pulled low
    output logic            input_good_n_o,           // input good drive level
    output logic            input_good_n_oe,          // input good pulled low
    output logic            event_n_o,                // event line drive level
    output logic            event_n_oe,               // event line pulled low
    output logic            charge_en_q,              // charging enabled
    output logic            boost_en_q,               // boost enabled
    output logic [2:0]      input_current_limit_q,    // effective limit code
    output logic            battery_switch_q          // battery switch closed
);
    localparam int unsigned EW = $clog2(EVENT_CYC);
    localparam logic [EW-1:0] EV_LAST = EW'(EVENT_CYC - 1);

    function automatic logic [2:0] lim_min(input logic [2:0] a, input logic [2:0] b);
        lim_min = (a < b) ? a : b;
    endfunction : lim_min

    logic          blink_phase;
    logic          ship_exit;
    logic          fault_q;
    logic          ev_pend_q;
    logic [EW-1:0] ev_cnt_q;
    cpc_ev_state_t ev_state_q;
    logic          boost_mode;
    logic [2:0]    usb_lim;
    logic [2:0]    lim_d;
    logic          ev_trig;
    logic [31:0]   ship_hi_q;

    cpc_half_divider #(
        .HALF_CYC (BLINK_HALF)
    ) u_blink (
        .mclk    (mclk),
        .rst     (rst),
        .en      (fault_any),
        .phase_q (blink_phase)
    );

    cpc_ship_exit #(
        .HOLD_CYC (SHIP_CYC)
    ) u_ship (
        .mclk   (mclk),
        .rst    (rst),
        .pin    (ship_exit_pin),
        .exit_q (ship_exit)
    );

    // ship high count, checker helper only
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            ship_hi_q <= '0;
        end else if (!ship_exit_pin) begin
            ship_hi_q <= '0;
        end else if (ship_hi_q != '1) begin
            ship_hi_q <= ship_hi_q + 32'h1;
        end
    end

    // open-drain pins only ever drive low
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            stat_o         <= 1'b0;
            input_good_n_o <= 1'b0;
            event_n_o      <= 1'b0;
        end else begin
            stat_o         <= 1'b0;
            input_good_n_o <= 1'b0;
            event_n_o      <= 1'b0;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            boost_en_q <= 1'b0;
        end else begin
            boost_en_q <= charge_config_reg[CFG_BOOST_BIT] && host_limit_boost_pin
                          && thermistor_sense;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            charge_en_q <= 1'b0;
        end else begin
            charge_en_q <= (charge_config_reg[CFG_MODE_HI:CFG_MODE_LO] == CFG_MODE_CHARGE)
                           && !charge_enable_n_pin && thermistor_sense;
        end
    end

    assign boost_mode = charge_config_reg[CFG_BOOST_BIT] && host_limit_boost_pin;

    assign usb_lim = host_limit_boost_pin ? LIM_500MA : LIM_100MA;

    always_comb begin
        lim_d = lim_min(input_limit_resistor_pin, input_source_reg[SRC_LIM_HI:SRC_LIM_LO]);
        if (source_is_host && !boost_mode) begin
            lim_d = lim_min(lim_d, usb_lim);
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            input_current_limit_q <= LIM_RST;
        end else begin
            input_current_limit_q <= lim_d;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            input_good_n_oe <= 1'b0;
        end else begin
            input_good_n_oe <= above_undervoltage_lockout && !input_overvoltage
                               && above_sleep && !input_limit_zero;
        end
    end

    // status pin, fault blink overrides charge state
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            stat_oe <= 1'b0;
        end else if (fault_any) begin
            stat_oe <= blink_phase;
        end else begin
            stat_oe <= charging && charge_en_q;
        end
    end

    // battery switch, exit wins over a same-cycle enter
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            battery_switch_q <= BATSW_RST;
        end else if (ship_exit) begin
            battery_switch_q <= 1'b1;
        end else if (ship_enter) begin
            battery_switch_q <= 1'b0;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            fault_q <= 1'b0;
        end else begin
            fault_q <= fault_any;
        end
    end

    assign ev_trig = status_change || (fault_any && !fault_q);

    // events arriving mid-pulse are held in one pending flag, so several merge into one pulse
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            ev_pend_q <= 1'b0;
        end else if (ev_state_q == CPC_EV_PULSE && ev_trig) begin
            ev_pend_q <= 1'b1;
        end else if (ev_state_q == CPC_EV_IDLE) begin
            ev_pend_q <= 1'b0;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            ev_state_q <= CPC_EV_IDLE;
            ev_cnt_q   <= '0;
            event_n_oe <= 1'b0;
        end else begin
            unique case (ev_state_q)
                CPC_EV_IDLE: begin
                    ev_cnt_q <= '0;
                    if (ev_trig || ev_pend_q) begin
                        ev_state_q <= CPC_EV_PULSE;
                        event_n_oe <= 1'b1;
                    end
                end
                CPC_EV_PULSE: begin
                    ev_cnt_q <= ev_cnt_q + 1'b1;
                    if (ev_cnt_q == EV_LAST) begin
                        ev_state_q <= CPC_EV_IDLE;
                        event_n_oe <= 1'b0;
                    end
                end
            endcase
        end
    end

    // one idle cycle always separates two pulses so the host sees both edges

    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    AST_STAT_CHARGE: assert property (
        !fault_any && charging && charge_en_q |=> stat_oe || fault_any
    ) else $error("status pin not low while charging");

    AST_STAT_IDLE: assert property (
        !fault_any && !charge_en_q |=> !stat_oe || fault_any || $past(charge_en_q)
    ) else $error("status pin low while not charging");

    AST_STAT_BLINK: assert property (
        fault_any && $past(fault_any) |=> stat_oe == $past(blink_phase)
    ) else $error("status pin not following blink during fault");

    AST_EVENT_LEN: assert property (
        ev_state_q == CPC_EV_PULSE && ev_cnt_q == EV_LAST |=> !event_n_oe
    ) else $error("event pulse not released at end");

    AST_EVENT_HOLD: assert property (
        event_n_oe && ev_cnt_q != EV_LAST |=> event_n_oe
    ) else $error("event pulse ended early");

    AST_EVENT_START: assert property (
        $rose(event_n_oe) |-> ev_cnt_q == '0 && $past(ev_state_q) == CPC_EV_IDLE
    ) else $error("event pulse started mid count");

    AST_USB_LIMIT: assert property (
        source_is_host && !boost_mode && !host_limit_boost_pin
        |=> input_current_limit_q == LIM_100MA
    ) else $error("host source low limit not applied");

    AST_BOOST_GATE: assert property (
        boost_en_q |-> $past(charge_config_reg[CFG_BOOST_BIT]) && $past(host_limit_boost_pin)
    ) else $error("boost enabled without config and pin");

    AST_CHARGE_GATE: assert property (
        charge_en_q |-> !$past(charge_enable_n_pin)
        && $past(charge_config_reg[CFG_MODE_HI:CFG_MODE_LO]) == CFG_MODE_CHARGE
    ) else $error("charging enabled without config and pin");

    AST_LIMIT_MIN: assert property (
        ##1 input_current_limit_q <= $past(input_limit_resistor_pin)
        && input_current_limit_q <= $past(input_source_reg[SRC_LIM_HI:SRC_LIM_LO])
    ) else $error("limit above resistor or register");

    AST_INPUT_GOOD: assert property (
        input_good_n_oe |-> $past(above_undervoltage_lockout) && !$past(input_overvoltage)
        && $past(above_sleep) && !$past(input_limit_zero)
    ) else $error("input good asserted for bad input");

    AST_SHIP_EXIT: assert property (
        ship_exit |=> battery_switch_q
    ) else $error("battery switch not closed after exit");

    AST_THERM_GATE: assert property (
        !thermistor_sense |=> !charge_en_q && !boost_en_q
    ) else $error("charge or boost on outside thermistor window");

    AST_SHIP_MIN: assert property (
        ship_exit |-> ship_hi_q >= SHIP_CYC
    ) else $error("ship exit before minimum high time");

    AST_BATSW_HOLD: assert property (
        !ship_exit && !ship_enter |=> battery_switch_q == $past(battery_switch_q)
    ) else $error("battery switch changed with no request");

    COV_EVENT: cover property ($fell(event_n_oe));
    COV_BLINK: cover property (fault_any && $fell(stat_oe));
    COV_SHIP: cover property (ship_exit);
    COV_BOOST: cover property (boost_en_q);
    COV_EVENT_PEND: cover property (ev_pend_q && $fell(event_n_oe));
endmodule : cpc_pin_control

// ==== verif/cpc_host_model.sv ====
`timescale 1ns/10ps
module cpc_host_model (
    input  wire logic stat_o,              // status drive level
    input  wire logic stat_oe,             // status pulled low
    input  wire logic input_good_n_o,      // input good drive level
    input  wire logic input_good_n_oe,     // input good pulled low
    input  wire logic event_n_o,           // event drive level
    input  wire logic event_n_oe,          // event pulled low
    input  wire logic ce_req,              // host wants charging
    output logic      stat_pin,            // status wire
    output logic      input_good_pin,      // input good wire
    output logic      event_pin,           // event wire
    output logic      charge_enable_n_pin  // charge enable wire
);
    // pull-ups: a released wire reads high
    assign stat_pin       = stat_oe ? stat_o : 1'b1;
    assign input_good_pin = input_good_n_oe ? input_good_n_o : 1'b1;
    assign event_pin      = event_n_oe ? event_n_o : 1'b1;
    assign charge_enable_n_pin = ~ce_req;
endmodule : cpc_host_model

// ==== verif/testbench.sv ====
`timescale 1ns/10ps
module testbench;
    import cpc_pkg::*;
    localparam int BH = 8;
    localparam int EC = 16;
    localparam int SC = 10;
    logic       mclk = 1'b0;
    logic       rst  = 1'b1;
    logic [7:0] cfg  = 8'h00;
    logic [7:0] src  = 8'h00;
    logic [2:0] rlim = 3'h7;
    logic hlb = 0, ce_req = 0, host = 0, therm = 1, chg = 0, flt = 0, stc = 0;
    logic above_lo = 0, ovp = 0, slp = 0, lz = 0, qpin = 0, sen = 0;
    logic so, soe, go, goe, eo, eoe, cen, ben, bsw, ce_n, spin, gpin, epin;
    logic [2:0] lim;
    int errors = 0;
    int compares = 0;
    always #5 mclk = ~mclk;
    cpc_pin_control #(.BLINK_HALF(BH), .EVENT_CYC(EC), .SHIP_CYC(SC)) uut (
        .mclk(mclk), .rst(rst), .charge_config_reg(cfg), .input_source_reg(src),
        .host_limit_boost_pin(hlb), .charge_enable_n_pin(ce_n), .source_is_host(host),
        .input_limit_resistor_pin(rlim), .thermistor_sense(therm), .charging(chg),
        .fault_any(flt), .status_change(stc), .above_undervoltage_lockout(above_lo),
        .input_overvoltage(ovp), .above_sleep(slp), .input_limit_zero(lz),
        .ship_exit_pin(qpin), .ship_enter(sen), .stat_o(so), .stat_oe(soe),
        .input_good_n_o(go), .input_good_n_oe(goe), .event_n_o(eo), .event_n_oe(eoe),
        .charge_en_q(cen), .boost_en_q(ben), .input_current_limit_q(lim),
        .battery_switch_q(bsw));
    cpc_host_model host_side (
        .stat_o(so), .stat_oe(soe), .input_good_n_o(go), .input_good_n_oe(goe),
        .event_n_o(eo), .event_n_oe(eoe), .ce_req(ce_req), .stat_pin(spin),
        .input_good_pin(gpin), .event_pin(epin), .charge_enable_n_pin(ce_n));

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("mismatch %s expected %0h seen %0h", nm, exp, got);
        end
    endtask : chk

    task automatic print_verdict;
        $display("errors %0d compares %0d", errors, compares);
        if (errors == 0 && compares > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : print_verdict

    function automatic logic [2:0] exp_lim();
        logic [2:0] m;
        m = (rlim < src[2:0]) ? rlim : src[2:0];
        // host limit only outside boost
        if (host && !(cfg[CFG_BOOST_BIT] && hlb))
            m = (m < (hlb ? LIM_500MA : LIM_100MA)) ? m : (hlb ? LIM_500MA : LIM_100MA);
        return m;
    endfunction : exp_lim

    function automatic logic pick(input int sel);
        return (sel == 0) ? eoe : soe;
    endfunction : pick

    // wait for a level, then count how long it stays
    task automatic run_len(input int sel, input logic lvl, output int n);
        int w;
        w = 0;
        n = 0;
        while (pick(sel) !== lvl && w < 60) begin
            @(negedge mclk);
            w++;
        end
        while (pick(sel) === lvl && n < 200) begin
            @(negedge mclk);
            n++;
        end
    endtask : run_len

    task automatic pulse_stc;
        @(posedge mclk);
        stc <= 1'b1;
        @(posedge mclk);
        stc <= 1'b0;
    endtask : pulse_stc

    initial begin
        #100000;
        errors++;
        print_verdict();
    end

    initial begin
        logic [31:0] v;
        int          n;
        v = $urandom(31323);
        repeat (3) @(posedge mclk);
        rst <= 1'b0;
        @(negedge mclk);
        chk("rst_bsw", 1, bsw);
        chk("rst_lim", LIM_RST, lim);
        chk("rst_event", 0, eoe);
        for (int i = 0; i < 200; i++) begin
            @(posedge mclk);
            v = $urandom;
            host  <= v[8];
            cfg   <= v[7:0];
            src   <= {5'h00, v[11:9]};
            rlim  <= v[14:12];
            hlb   <= v[15];
            ce_req <= v[16];
            therm <= v[17] | v[18];
            above_lo <= v[19] | v[20];
            ovp   <= v[21] & v[22];
            slp   <= v[23] | v[24];
            lz    <= v[25] & v[26];
            @(posedge mclk);
            @(negedge mclk);
            chk("charge_en", (cfg[5:4] == CFG_MODE_CHARGE) && !ce_n && therm, cen);
            chk("boost_en", cfg[CFG_BOOST_BIT] && hlb && therm, ben);
            chk("limit", exp_lim(), lim);
            chk("good_oe", above_lo && !ovp && slp && !lz, goe);
            chk("good_pin", !(above_lo && !ovp && slp && !lz), gpin);
        end
        @(posedge mclk);
        cfg <= 8'h10;
        ce_req <= 1'b1;
        therm <= 1'b1;
        chg <= 1'b1;
        repeat (3) @(posedge mclk);
        @(negedge mclk);
        chk("stat_chg", 0, spin);
        @(posedge mclk);
        chg <= 1'b0;
        repeat (3) @(posedge mclk);
        @(negedge mclk);
        chk("stat_idle", 1, spin);
        pulse_stc();
        run_len(0, 1, n);
        chk("event_len", EC, n);
        // trigger inside a pulse is kept
        pulse_stc();
        repeat (4) @(negedge mclk);
        chk("event_pin", 0, epin);
        pulse_stc();
        run_len(0, 1, n);
        run_len(0, 0, n);
        chk("event_gap", 1, n);
        run_len(0, 1, n);
        chk("event_len2", EC, n);
        repeat (4) @(posedge mclk);
        flt <= 1'b1;
        repeat (2) @(negedge mclk);
        chk("fault_event", 1, eoe);
        run_len(1, 1, n);
        chk("blink_low", BH, n);
        run_len(1, 0, n);
        chk("blink_high", BH, n);
        @(posedge mclk);
        flt <= 1'b0;
        sen <= 1'b1;
        @(posedge mclk);
        sen <= 1'b0;
        repeat (2) @(negedge mclk);
        chk("ship_open", 0, bsw);
        @(posedge mclk);
        qpin <= 1'b1;
        repeat (SC / 2) @(posedge mclk);
        qpin <= 1'b0;
        repeat (SC + 4) @(posedge mclk);
        qpin <= 1'b1;
        repeat (SC - 2) @(negedge mclk);
        chk("ship_short", 0, bsw);
        repeat (8) @(negedge mclk);
        chk("ship_exit", 1, bsw);
        print_verdict();
    end
endmodule : testbench
